//--- hdl/fbci_defs.svh
// Purpose: constants for the flash bus command host controller
// Assumes: 40 MHz system clock
// Notes:   codes and strobe timing in cycles
`ifndef FBCI_DEFS_SVH
`define FBCI_DEFS_SVH
`define FBCI_CMD_READ       8'h00
`define FBCI_CMD_READ_CONF  8'h30
`define FBCI_CMD_CACHE_RD   8'h31
`define FBCI_CMD_EXIT_CACHE 8'h34
`define FBCI_CMD_COPY_RD    8'h35
`define FBCI_CMD_RND_OUT    8'h05
`define FBCI_CMD_RND_OUT_C  8'he0
`define FBCI_CMD_PROG       8'h80
`define FBCI_CMD_PROG_CONF  8'h10
`define FBCI_CMD_CACHE_PROG 8'h15
`define FBCI_CMD_RND_IN     8'h85
`define FBCI_CMD_ERASE      8'h60
`define FBCI_CMD_ERASE_CONF 8'hd0
`define FBCI_CMD_RESET      8'hff
`define FBCI_CMD_SIGNATURE  8'h90
`define FBCI_CMD_STATUS     8'h70
`define FBCI_CMD_LOCK_STAT  8'h7a
`define FBCI_CMD_UNLOCK     8'h23
`define FBCI_CMD_UNLOCK_C   8'h24
`define FBCI_CMD_LOCK       8'h2a
`define FBCI_CMD_LOCKDOWN   8'h2c
// Strobe phase length: 25 ns minimum, at 25 ns period gives one cycle
`define FBCI_PHASE_NS       25
`define FBCI_CLK_NS         25
`define FBCI_PHASE_CYC      ((`FBCI_PHASE_NS + `FBCI_CLK_NS - 1) / `FBCI_CLK_NS)
`endif

//--- hdl/fbci_pkg.sv
// Purpose: types for the flash bus command host controller
// Assumes: used with fbci_defs.svh
// Notes:   bus cycle kinds and request carrier
package fbci_pkg;
    typedef enum logic [2:0] {
        FBCI_OP_CMD  = 3'b000,
        FBCI_OP_ADDR = 3'b001,
        FBCI_OP_DIN  = 3'b010,
        FBCI_OP_DOUT = 3'b011,
        FBCI_OP_SEQ  = 3'b100
    } fbci_op_e;
    typedef struct packed {
        fbci_op_e    op;
        logic [7:0]  cmd;
        logic [7:0]  cmd2;
        logic [15:0] data;
        logic [30:0] addr;
        logic [2:0]  naddr;
        logic        col_only;
        logic        has_cmd2;
    } fbci_req_s;
    typedef struct packed {
        logic        ce_n;
        logic        cle;
        logic        ale;
        logic        we_n;
        logic        re_n;
        logic        wp_n;
    } fbci_pins_s;
endpackage

//--- hdl/fbci_host.sv
// Purpose: host that drives the flash strobes and I/O bus
// Assumes: one request at a time; pins are synchronous to i_sys_clk
// Notes:   each write/read pulse is low one phase and high one phase
`timescale 1ns/1ps
`include "fbci_defs.svh"
module fbci_host #(
    parameter int WIDE    = 0,
    parameter int DENSITY = 0
) (
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst,
    input  wire fbci_pkg::fbci_req_s i_req,
    input  wire logic              i_req_valid,
    output logic                   o_req_ready,
    input  wire logic              i_ready_busy,
    input  wire logic              i_wp_allow,
    input  wire logic [15:0]       i_io,
    output logic [15:0]            o_io,
    output logic                   o_io_oe,
    output fbci_pkg::fbci_pins_s   o_pins,
    output logic [15:0]            o_rdata,
    output logic                   o_rdata_valid,
    output logic                   o_refused
);
    import fbci_pkg::*;

    // Density 0..3 = 1, 2, 4, 8 Gb; width 0 byte, 1 word; others refused at elaboration
    if (DENSITY < 0 || DENSITY > 3 || WIDE < 0 || WIDE > 1) begin : g_param_check
        $error("fbci_host: unsupported density or width");
    end

    localparam logic [2:0] NADDR_FULL = (DENSITY == 0) ? 3'h4 : 3'h5;
    localparam logic [1:0] PH_LAST    = 2'(`FBCI_PHASE_CYC - 1);

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CMD   = 3'b001,
        ST_ADDR  = 3'b010,
        ST_DATA  = 3'b011,
        ST_CMD2  = 3'b100,
        ST_DONE  = 3'b101
    } fbci_st_e;

    // Address byte for a given cycle; upper I/O never carries address
    function automatic logic [7:0] addr_byte(input logic [30:0] a, input logic [2:0] n);
        logic [7:0] b;
        b = 8'h00;
        if (WIDE == 0) begin
            unique case (n)
                3'h0: b = a[7:0];
                3'h1: b = {4'h0, a[11:8]};
                3'h2: b = a[19:12];
                3'h3: b = a[27:20];
                default: b = {5'h00, a[30:28] & (3'h7 >> (3 - DENSITY))};
            endcase
        end else begin
            unique case (n)
                3'h0: b = a[7:0];
                3'h1: b = {5'h00, a[10:8]};
                3'h2: b = a[18:11];
                3'h3: b = a[26:19];
                default: b = {5'h00, a[29:27] & (3'h7 >> (3 - DENSITY))};
            endcase
        end
        return b;
    endfunction

    function automatic logic is_write_code(input logic [7:0] c);
        return c == `FBCI_CMD_PROG || c == `FBCI_CMD_ERASE || c == `FBCI_CMD_RND_IN
            || c == `FBCI_CMD_PROG_CONF || c == `FBCI_CMD_CACHE_PROG || c == `FBCI_CMD_ERASE_CONF;
    endfunction

    function automatic logic code_known(input logic [7:0] c);
        unique case (c)
            `FBCI_CMD_READ, `FBCI_CMD_RND_OUT, `FBCI_CMD_EXIT_CACHE, `FBCI_CMD_PROG,
            `FBCI_CMD_RND_IN, `FBCI_CMD_ERASE, `FBCI_CMD_RESET, `FBCI_CMD_SIGNATURE,
            `FBCI_CMD_STATUS, `FBCI_CMD_LOCK_STAT, `FBCI_CMD_UNLOCK, `FBCI_CMD_LOCK,
            `FBCI_CMD_LOCKDOWN, `FBCI_CMD_READ_CONF, `FBCI_CMD_CACHE_RD, `FBCI_CMD_COPY_RD,
            `FBCI_CMD_RND_OUT_C, `FBCI_CMD_PROG_CONF, `FBCI_CMD_CACHE_PROG,
            `FBCI_CMD_ERASE_CONF, `FBCI_CMD_UNLOCK_C: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    fbci_st_e    st_q, st_d;
    fbci_req_s   req_q, req_d;
    logic        low_q, low_d;      // Strobe currently in its low phase
    logic [1:0]  ph_q, ph_d;
    logic [2:0]  acnt_q, acnt_d;
    fbci_pins_s  pins_q, pins_d;
    logic [15:0] io_q, io_d;
    logic        oe_q, oe_d;
    logic [15:0] rdata_q, rdata_d;
    logic        rvalid_q, rvalid_d;
    logic        refused_q, refused_d;
    logic        busy_cache_q, busy_cache_d;
    logic        phase_end;
    logic        busy_ok;

    assign phase_end = (ph_q == PH_LAST);
    // While busy only reset, status, and exit-cache in a cache read may go out
    assign busy_ok = i_req.cmd == `FBCI_CMD_RESET || i_req.cmd == `FBCI_CMD_STATUS
                   || (i_req.cmd == `FBCI_CMD_EXIT_CACHE && busy_cache_q);

    // Sequencer next state: one bus cycle is a low phase then a high phase
    always_comb begin
        st_d         = st_q;
        req_d        = req_q;
        low_d        = low_q;
        ph_d         = phase_end ? 2'h0 : ph_q + 2'h1;
        acnt_d       = acnt_q;
        pins_d       = pins_q;
        io_d         = io_q;
        oe_d         = oe_q;
        rdata_d      = rdata_q;
        rvalid_d     = 1'b0;
        refused_d    = 1'b0;
        busy_cache_d = busy_cache_q;
        o_req_ready  = (st_q == ST_IDLE);
        unique case (st_q)
            ST_IDLE: begin
                pins_d = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1,
                           wp_n: i_wp_allow};
                oe_d   = 1'b0;
                ph_d   = 2'h0;
                low_d  = 1'b0;
                if (i_req_valid) begin
                    if (((i_req.op == FBCI_OP_CMD || i_req.op == FBCI_OP_SEQ) && !code_known(i_req.cmd))
                        || (!i_ready_busy && !(i_req.op == FBCI_OP_CMD && busy_ok))
                        || (is_write_code(i_req.cmd) && !i_wp_allow
                            && (i_req.op == FBCI_OP_CMD || i_req.op == FBCI_OP_SEQ))) begin
                        refused_d = 1'b1;
                    end else begin
                        req_d    = i_req;
                        acnt_d   = 3'h0;
                        pins_d.ce_n = 1'b0;
                        pins_d.wp_n = i_wp_allow | ~is_write_code(i_req.cmd);
                        unique case (i_req.op)
                            FBCI_OP_ADDR: st_d = ST_ADDR;
                            FBCI_OP_DIN, FBCI_OP_DOUT: st_d = ST_DATA;
                            default: st_d = ST_CMD;
                        endcase
                        if (i_req.op == FBCI_OP_CMD || i_req.op == FBCI_OP_SEQ) begin
                            busy_cache_d = (i_req.cmd2 == `FBCI_CMD_CACHE_RD) && i_req.has_cmd2;
                            if (i_req.cmd == `FBCI_CMD_EXIT_CACHE) begin
                                busy_cache_d = 1'b0;
                            end
                        end
                    end
                end
            end
            ST_CMD, ST_CMD2: begin
                // Command cycle: cle high, ale low, read high, low byte only
                pins_d.cle = 1'b1;
                pins_d.ale = 1'b0;
                pins_d.re_n = 1'b1;
                oe_d = 1'b1;
                io_d = {8'h00, (st_q == ST_CMD) ? req_q.cmd : req_q.cmd2};
                if (phase_end) begin
                    if (!low_q) begin
                        pins_d.we_n = 1'b0;
                        low_d = 1'b1;
                    end else begin
                        pins_d.we_n = 1'b1; // Rising edge latches the code
                        low_d = 1'b0;
                        if (st_q == ST_CMD && req_q.op == FBCI_OP_SEQ && req_q.naddr != 3'h0) begin
                            st_d = ST_ADDR;
                        end else if (st_q == ST_CMD && req_q.op == FBCI_OP_SEQ && req_q.has_cmd2) begin
                            st_d = ST_CMD2;
                        end else begin
                            st_d = ST_DONE;
                        end
                    end
                end
            end
            ST_ADDR: begin
                pins_d.cle = 1'b0;
                pins_d.ale = 1'b1;
                pins_d.re_n = 1'b1;
                oe_d = 1'b1;
                io_d = {8'h00, addr_byte(req_q.addr, acnt_q)};
                if (phase_end) begin
                    if (!low_q) begin
                        pins_d.we_n = 1'b0;
                        low_d = 1'b1;
                    end else begin
                        pins_d.we_n = 1'b1;
                        low_d = 1'b0;
                        acnt_d = acnt_q + 3'h1;
                        // Column-only sends two cycles; never beyond the density count
                        if (acnt_q + 3'h1 >= (req_q.col_only ? 3'h2 : NADDR_FULL)) begin
                            st_d = (req_q.op == FBCI_OP_SEQ && req_q.has_cmd2) ? ST_CMD2 : ST_DONE;
                        end
                    end
                end
            end
            ST_DATA: begin
                pins_d.cle = 1'b0;
                pins_d.ale = 1'b0;
                if (req_q.op == FBCI_OP_DIN) begin
                    oe_d = 1'b1;
                    io_d = (WIDE != 0) ? req_q.data : {8'h00, req_q.data[7:0]};
                    if (phase_end) begin
                        pins_d.we_n = low_q;
                        low_d = ~low_q;
                        st_d = low_q ? ST_DONE : ST_DATA;
                    end
                end else begin
                    oe_d = 1'b0;
                    pins_d.we_n = 1'b1;
                    if (phase_end) begin
                        pins_d.re_n = low_q;
                        low_d = ~low_q;
                        if (low_q) begin
                            rdata_d  = (WIDE != 0) ? i_io : {8'h00, i_io[7:0]};
                            rvalid_d = 1'b1;
                            st_d     = ST_DONE;
                        end
                    end
                end
            end
            ST_DONE: begin
                // Leave latch strobes low; chip enable raised for standby
                pins_d = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1,
                           wp_n: i_wp_allow};
                oe_d = 1'b0;
                st_d = ST_IDLE;
            end
            default: st_d = ST_IDLE;
        endcase
    end

    // Registers
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            st_q         <= ST_IDLE;
            req_q        <= '0;
            low_q        <= 1'b0;
            ph_q         <= 2'h0;
            acnt_q       <= 3'h0;
            pins_q       <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1, wp_n: 1'b0};
            io_q         <= 16'h0000;
            oe_q         <= 1'b0;
            rdata_q      <= 16'h0000;
            rvalid_q     <= 1'b0;
            refused_q    <= 1'b0;
            busy_cache_q <= 1'b0;
        end else begin
            st_q         <= st_d;
            req_q        <= req_d;
            low_q        <= low_d;
            ph_q         <= ph_d;
            acnt_q       <= acnt_d;
            pins_q       <= pins_d;
            io_q         <= io_d;
            oe_q         <= oe_d;
            rdata_q      <= rdata_d;
            rvalid_q     <= rvalid_d;
            refused_q    <= refused_d;
            busy_cache_q <= busy_cache_d;
        end
    end

    assign o_pins        = pins_q;
    assign o_io          = io_q;
    assign o_io_oe       = oe_q;
    assign o_rdata       = rdata_q;
    assign o_rdata_valid = rvalid_q;
    assign o_refused     = refused_q;

    // Latch strobes never high together
    latch_excl_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !(o_pins.cle && o_pins.ale)) else $error("both latch strobes high");
    // Write strobe low only with chip enable low
    we_select_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !o_pins.we_n |-> !o_pins.ce_n) else $error("write strobe without select");
    // Command cycle keeps read strobe high and drives bus
    cmd_cycle_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (o_pins.cle && !o_pins.we_n) |-> (o_pins.re_n && o_io_oe && o_io[15:8] == 8'h00))
        else $error("bad command cycle");
    // Write codes go out only with protect released
    wp_high_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (o_pins.cle && !o_pins.we_n && is_write_code(o_io[7:0])) |-> o_pins.wp_n)
        else $error("write code with protect low");
    // Data read never while host drives bus
    read_drive_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !o_pins.re_n |-> (!o_io_oe && o_pins.we_n && !o_pins.cle && !o_pins.ale))
        else $error("read strobe with bus driven");
    // Address cycle count never exceeds density need
    addr_count_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (st_q == ST_ADDR) |-> (acnt_q < NADDR_FULL)) else $error("too many address cycles");
    // Done returns chip enable high and releases the bus on the next cycle
    standby_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (st_q == ST_DONE) |=> (o_pins.ce_n && !o_io_oe)) else $error("no standby after op");
    // Busy refusal for a data-input request
    busy_ref_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (st_q == ST_IDLE && i_req_valid && !i_ready_busy && i_req.op == FBCI_OP_DIN)
        |=> (o_refused && st_q == ST_IDLE)) else $error("busy not refused");
endmodule

//--- dv/fbci_dev_model.sv
// Purpose: behavioural flash device facing the host controller
// Assumes: byte-wide part; pins change only on host clock edges
// Notes:   logs each latched bus cycle as {kind, wp_n, bus}
`timescale 1ns/1ps
module fbci_dev_model (
    input  wire fbci_pkg::fbci_pins_s i_pins,
    input  wire logic [15:0]          i_io,
    input  wire logic                 i_busy,
    output logic [15:0]               o_io,
    output logic                      o_ready_busy
);
    import fbci_pkg::*;
    logic [18:0] log_q[$];
    logic [7:0]  col_q      = 8'hc3;
    logic [7:0]  out_q      = 8'h00;
    logic        wp_fault   = 1'b0;
    logic        busy_fault = 1'b0;
    logic        drive;
    // Busy level comes from the bench
    assign o_ready_busy = ~i_busy;
    // Drive only when selected, write high and both latches low
    assign drive = !i_pins.ce_n && i_pins.we_n && !i_pins.cle && !i_pins.ale;
    // A released bus shows the inverse, so stale data never matches
    assign o_io = drive ? {~out_q, out_q} : {out_q, ~out_q};
    // Each read strobe fall presents the current column, then steps it
    always @(negedge i_pins.re_n) begin
        if (i_pins.ce_n === 1'b0) begin
            out_q <= col_q;
            col_q <= col_q + 8'h01;
        end
    end
    // Rising write strobe latches one cycle; upper bits ignored on data cycles of a byte part
    always @(posedge i_pins.we_n) begin
        if (i_pins.ce_n === 1'b0) begin
            if (i_pins.cle) log_q.push_back({2'h0, i_pins.wp_n, i_io});
            else if (i_pins.ale) log_q.push_back({2'h1, 1'b0, i_io});
            else log_q.push_back({2'h2, 1'b0, 8'h00, i_io[7:0]});
            // Program, erase or random-input setup codes (80h, 60h, 85h) while protected would be refused
            if (i_pins.cle && !i_pins.wp_n && i_io[7:0] inside {8'h80, 8'h60, 8'h85}) wp_fault <= 1'b1;
            // A busy part takes only reset, status and exit cache
            if (i_busy && i_pins.cle && !(i_io[7:0] inside {8'hff, 8'h70, 8'h34})) busy_fault <= 1'b1;
        end
    end
endmodule

//--- dv/flash_bus_command_interface_tb.sv
// Purpose: self-checking bench for the flash host controller
// Assumes: byte-wide part at 4 Gb, so five address cycles, two top bits
// Notes:   expected bus cycles are rebuilt here and matched to the model log
`timescale 1ns/1ps
module flash_bus_command_interface_tb;
    import fbci_pkg::*;
    logic        i_sys_clk = 1'b0;
    logic        i_rst     = 1'b1;
    fbci_req_s   req       = '0;
    logic        req_valid = 1'b0;
    logic        wp_allow  = 1'b1;
    logic        busy      = 1'b0;
    logic        req_ready, io_oe, rdata_valid, refused, ready_busy;
    logic [15:0] host_io, dev_io, bus, rdata;
    logic [15:0] last_rd   = 16'h0000;
    fbci_pins_s  pins;
    int          n_errors  = 0;
    int          checked   = 0;
    int          n_ref     = 0;
    logic [18:0] exp_q[$];
    localparam logic [30:0] ADR = 31'h5bcd_e9a7;
    // 40 MHz clock
    always #12.5 i_sys_clk = ~i_sys_clk;
    // Bus level: host when it drives, else the device side
    assign bus = io_oe ? host_io : dev_io;
    fbci_host #(.WIDE(0), .DENSITY(2)) dut (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_req(req), .i_req_valid(req_valid),
        .o_req_ready(req_ready), .i_ready_busy(ready_busy), .i_wp_allow(wp_allow), .i_io(bus),
        .o_io(host_io), .o_io_oe(io_oe), .o_pins(pins), .o_rdata(rdata),
        .o_rdata_valid(rdata_valid), .o_refused(refused));
    fbci_dev_model model (.i_pins(pins), .i_io(host_io), .i_busy(busy), .o_io(dev_io),
        .o_ready_busy(ready_busy));
    // One-cycle pulses are caught in the cycle they stand
    always @(posedge i_sys_clk) begin
        if (refused === 1'b1) n_ref <= n_ref + 1;
        if (rdata_valid === 1'b1) last_rd <= rdata;
    end
    task automatic chk(input logic [18:0] got, input logic [18:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checked %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // One request, held from a falling edge until taken, then wait for idle
    task automatic send(input fbci_op_e op, input logic [7:0] c, input logic [7:0] c2,
                        input logic col, input logic h2, input logic [15:0] d);
        int n;
        @(negedge i_sys_clk);
        req = '{op: op, cmd: c, cmd2: c2, data: d, addr: ADR, naddr: 3'h1, col_only: col, has_cmd2: h2};
        req_valid = 1'b1;
        for (n = 0; n < 50 && req_ready !== 1'b1; n++) @(negedge i_sys_clk);
        @(negedge i_sys_clk);
        req_valid = 1'b0;
        for (n = 0; n < 300 && req_ready !== 1'b1; n++) @(negedge i_sys_clk);
        chk(19'(req_ready), 19'h1, "back to idle");
        @(negedge i_sys_clk);
    endtask
    // Column bytes, then row bytes; fifth cycle keeps two bits at 4 Gb
    function automatic void ex_addr(input logic col);
        exp_q.push_back({3'h2, 8'h00, ADR[7:0]});
        exp_q.push_back({3'h2, 12'h000, ADR[11:8]});
        if (!col) begin
            exp_q.push_back({3'h2, 8'h00, ADR[19:12]});
            exp_q.push_back({3'h2, 8'h00, ADR[27:20]});
            exp_q.push_back({3'h2, 14'h0000, ADR[29:28]});
        end
    endfunction
    task automatic chk_log(input string what);
        chk(19'(model.log_q.size()), 19'(exp_q.size()), what);
        foreach (exp_q[i]) if (i < model.log_q.size()) chk(model.log_q[i], exp_q[i], what);
        model.log_q.delete();
        exp_q.delete();
    endtask
    // Two-step sequences, random input, and a read without its setup code
    task automatic t_seqs();
        logic [17:0] tb [7] = '{{8'h00, 8'h30, 2'h1}, {8'h00, 8'h31, 2'h1}, {8'h00, 8'h35, 2'h1},
            {8'h05, 8'he0, 2'h3}, {8'h60, 8'hd0, 2'h1}, {8'h23, 8'h24, 2'h1}, {8'h85, 8'h00, 2'h2}};
        foreach (tb[i]) begin
            send(FBCI_OP_SEQ, tb[i][17:10], tb[i][9:2], tb[i][1], tb[i][0], 16'h0000);
            exp_q.push_back({3'h1, 8'h00, tb[i][17:10]});
            ex_addr(tb[i][1]);
            if (tb[i][0]) exp_q.push_back({3'h1, 8'h00, tb[i][9:2]});
            chk_log("sequence");
        end
        send(FBCI_OP_ADDR, 8'h00, 8'h00, 1'b0, 1'b0, 16'h0000);
        send(FBCI_OP_CMD, 8'h30, 8'h00, 1'b0, 1'b0, 16'h0000);
        ex_addr(1'b0);
        exp_q.push_back({3'h1, 8'h00, 8'h30});
        chk_log("read without setup");
    endtask
    // Program with data between setup and confirm, protect held high
    task automatic t_prog();
        send(FBCI_OP_SEQ, 8'h80, 8'h00, 1'b0, 1'b0, 16'h0000);
        send(FBCI_OP_DIN, 8'h00, 8'h00, 1'b0, 1'b0, 16'h5a3c);
        send(FBCI_OP_CMD, 8'h10, 8'h00, 1'b0, 1'b0, 16'h0000);
        exp_q.push_back({3'h1, 8'h00, 8'h80});
        ex_addr(1'b0);
        exp_q.push_back({3'h4, 8'h00, 8'h3c});
        exp_q.push_back({3'h1, 8'h00, 8'h10});
        chk_log("program");
    endtask
    // Single-cycle codes all reach the device
    task automatic t_single();
        logic [7:0] cs [6] = '{8'hff, 8'h90, 8'h70, 8'h7a, 8'h2a, 8'h2c};
        foreach (cs[i]) begin
            send(FBCI_OP_CMD, cs[i], 8'h00, 1'b0, 1'b0, 16'h0000);
            exp_q.push_back({3'h1, 8'h00, cs[i]});
        end
        chk_log("single codes");
    endtask
    // Protected writes, an unknown code and busy-time codes
    task automatic t_refuse();
        wp_allow = 1'b0;
        send(FBCI_OP_SEQ, 8'h80, 8'h10, 1'b0, 1'b1, 16'h0000);
        send(FBCI_OP_SEQ, 8'h60, 8'hd0, 1'b0, 1'b1, 16'h0000);
        wp_allow = 1'b1;
        send(FBCI_OP_CMD, 8'h11, 8'h00, 1'b0, 1'b0, 16'h0000);
        chk(19'(n_ref), 19'h3, "refusals");
        busy = 1'b1;
        send(FBCI_OP_CMD, 8'h00, 8'h00, 1'b0, 1'b0, 16'h0000);
        send(FBCI_OP_DIN, 8'h00, 8'h00, 1'b0, 1'b0, 16'h1234);
        send(FBCI_OP_CMD, 8'h34, 8'h00, 1'b0, 1'b0, 16'h0000);
        send(FBCI_OP_CMD, 8'h70, 8'h00, 1'b0, 1'b0, 16'h0000);
        send(FBCI_OP_CMD, 8'hff, 8'h00, 1'b0, 1'b0, 16'h0000);
        busy = 1'b0;
        chk(19'(n_ref), 19'h6, "busy refusal");
        // Exit cache is let through only while a cache read keeps the part busy
        send(FBCI_OP_SEQ, 8'h00, 8'h31, 1'b0, 1'b1, 16'h0000);
        busy = 1'b1;
        send(FBCI_OP_CMD, 8'h34, 8'h00, 1'b0, 1'b0, 16'h0000);
        busy = 1'b0;
        chk(19'(n_ref), 19'h6, "exit cache in cache busy");
        exp_q.push_back({3'h1, 8'h00, 8'h70});
        exp_q.push_back({3'h1, 8'h00, 8'hff});
        exp_q.push_back({3'h1, 8'h00, 8'h00});
        ex_addr(1'b0);
        exp_q.push_back({3'h1, 8'h00, 8'h31});
        exp_q.push_back({3'h1, 8'h00, 8'h34});
        chk_log("refused leave bus quiet");
    endtask
    // Read words step by one per read strobe fall
    task automatic t_dout();
        send(FBCI_OP_DOUT, 8'h00, 8'h00, 1'b0, 1'b0, 16'h0000);
        chk(19'(last_rd), 19'h00c3, "first word");
        send(FBCI_OP_DOUT, 8'h00, 8'h00, 1'b0, 1'b0, 16'h0000);
        chk(19'(last_rd), 19'h00c4, "second word");
    endtask
    // Reset, then scenarios; idle must leave the part deselected
    initial begin
        repeat (11) @(negedge i_sys_clk);
        chk({12'h000, io_oe, pins}, 19'h26, "reset pins");
        @(negedge i_sys_clk);
        i_rst = 1'b0;
        t_seqs();
        t_prog();
        t_single();
        t_refuse();
        t_dout();
        chk({17'h0, model.wp_fault, model.busy_fault}, 19'h0, "device faults");
        chk({17'h0, pins.ce_n, io_oe}, 19'h2, "idle deselect");
        stop_test();
    end
    // Watchdog well beyond the expected run
    initial begin
        #(25 * 20000);
        n_errors++;
        stop_test();
    end
endmodule
